// File: verilog/trig_cond_map.vh
// Register map, field layout and timing constants of the trigger conditioner
//
// Contract
// R01: Route conditioned line to one of four functions
// R02: Acquisition start function gets acquisition start event
// R03: Frame start function gets frame start event
// R04: Frame counter reset clears frame counter
// R05: Trigger counter reset clears trigger input counter
// R06: Frame start trigger selected after reset
// R07: External source supplies timing suiting selected function
// R08: Pass new level only after stable debounce time
// R09: Pulses shorter than debounce time are discarded
// R10: Accepted transitions delayed by debounce time
// R11: Debounce time 0 to 20 us, whole us
// R12: Software sets debounce slightly above longest glitch
// R13: Polarity flip inverts input when set
// R14: Software selects line before writing line settings
// R15: Invert before debouncer, debounced result to edges
// R16: Debouncer holds output, restarts count on change
`ifndef TRIG_COND_MAP_VH
`define TRIG_COND_MAP_VH

// Register byte addresses
`define ADDR_ROUTE 4'h0
`define ADDR_FILTER 4'h4
`define ADDR_POLARITY 4'h8
`define ADDR_STATUS 4'hc
`define ADDR_FRAME_CNT 5'h10
`define ADDR_TRIG_CNT 5'h14

// Route select encodings
`define ROUTE_ACQ_START 2'h0
`define ROUTE_FRAME_START 2'h1
`define ROUTE_FRAME_CNT_RST 2'h2
`define ROUTE_TRIG_CNT_RST 2'h3
`define ROUTE_RESET `ROUTE_FRAME_START

// Debounce time
`define FILTER_US_MAX 5'h14
`define FILTER_US_RESET 5'h00
`define CLK_MHZ 200
`define CYCLES_PER_US 8'hc8

// Line selector: index of the opto input pin
`define LINE_INPUT 1'b0

`endif

// File: verilog/pin_sync.v
// Two-flop synchroniser for the opto input pin
`timescale 1ns/1ps
module pin_sync
(
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Pin and synchronised level
    input wire pin_in,
    output wire pin_sync_out
);
    reg stage1_reg;
    reg stage2_reg;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= pin_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign pin_sync_out = stage2_reg;
endmodule // pin_sync

// File: verilog/glitch_filter.v
// Stable-time debouncer with a microsecond-scaled cycle count
`timescale 1ns/1ps
`include "trig_cond_map.vh"
module glitch_filter
(
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Setting and level
    input wire [4:0] glitch_filter_time_us,
    input wire level_in,
    output wire level_out
);
    // 20 us at 200 MHz is 4000 cycles, fits in 12 bits
    wire [12:0] limit_full;
    wire [11:0] limit;
    reg [11:0] count_reg;
    reg cand_reg;
    reg out_reg;

    // Product is 13 bits wide; its top bit stays zero up to 20 us
    assign limit_full = glitch_filter_time_us * `CYCLES_PER_US;
    assign limit = limit_full[11:0];

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_reg <= 12'h000;
            cand_reg <= 1'b0;
            out_reg <= 1'b0;
        end
        else if (level_in == out_reg)
        begin
            // Back at the held level: a shorter pulse is dropped R09
            count_reg <= 12'h000;
            cand_reg <= level_in;
        end
        else if (level_in != cand_reg)
        begin
            cand_reg <= level_in;
            count_reg <= 12'h000; // R16
        end
        else if (count_reg + 12'h001 >= limit)
        begin
            // Zero setting passes a level held for two cycles; one-cycle pulses are still dropped R11
            out_reg <= level_in; // R08 R10
            count_reg <= 12'h000;
        end
        else
        begin
            count_reg <= count_reg + 12'h001; // R16
        end
    end

    assign level_out = out_reg;
endmodule // glitch_filter

// File: verilog/trigger_input_conditioner.v
// Opto input conditioner with AHB-Lite register access
`timescale 1ns/1ps
`include "trig_cond_map.vh"
module trigger_input_conditioner
(
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // Opto input pin
    input wire opto_input_pin,
    // Camera function events
    output wire acq_start_trig,
    output wire frame_start_trig,
    output wire frame_cnt_clear,
    output wire trig_cnt_clear,
    // Metadata counters
    input wire frame_done,
    output wire [31:0] frame_count,
    output wire [31:0] trig_count
);
    reg [1:0] pin_route_select_reg;
    reg [4:0] glitch_filter_time_us_reg;
    reg polarity_flip_reg;
    reg [31:0] frame_cnt_reg;
    reg [31:0] trig_cnt_reg;
    reg [31:0] rdata_reg;
    reg wr_pend_reg;
    reg [4:0] wr_addr_reg;
    reg filt_d_reg;
    wire pin_s;
    wire flipped;
    wire filtered;
    wire rise;
    wire take;
    wire [4:0] a;

    pin_sync u_sync
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(opto_input_pin),
        .pin_sync_out(pin_s)
    );

    assign flipped = pin_s ^ polarity_flip_reg; // R13 R15

    glitch_filter u_filter
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .glitch_filter_time_us(glitch_filter_time_us_reg),
        .level_in(flipped),
        .level_out(filtered)
    );

    // Rising edge of the debounced level is the event R15
    assign rise = filtered & ~filt_d_reg;

    // Exactly one function sees the event R01
    assign acq_start_trig = rise &
        (pin_route_select_reg == `ROUTE_ACQ_START); // R02
    assign frame_start_trig = rise &
        (pin_route_select_reg == `ROUTE_FRAME_START); // R03
    assign frame_cnt_clear = rise &
        (pin_route_select_reg == `ROUTE_FRAME_CNT_RST); // R04
    assign trig_cnt_clear = rise &
        (pin_route_select_reg == `ROUTE_TRIG_CNT_RST); // R05

    // Bus: zero wait states, always OKAY
    assign take = hsel & hready & htrans[1];
    assign a = haddr[4:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_reg;
    assign frame_count = frame_cnt_reg;
    assign trig_count = trig_cnt_reg;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            filt_d_reg <= 1'b0;
            frame_cnt_reg <= 32'h00000000;
            trig_cnt_reg <= 32'h00000000;
        end
        else
        begin
            filt_d_reg <= filtered;
            // Clear wins over a concurrent count so the reset is exact
            if (frame_cnt_clear)
                frame_cnt_reg <= 32'h00000000; // R04
            else if (frame_done)
                frame_cnt_reg <= frame_cnt_reg + 32'h00000001;
            if (trig_cnt_clear)
                trig_cnt_reg <= 32'h00000000; // R05
            else if (rise)
                trig_cnt_reg <= trig_cnt_reg + 32'h00000001;
        end
    end

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 5'h00;
            pin_route_select_reg <= `ROUTE_RESET; // R06
            glitch_filter_time_us_reg <= `FILTER_US_RESET;
            polarity_flip_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            if (hready)
            begin
                wr_pend_reg <= take & hwrite;
                wr_addr_reg <= a;
            end
            if (wr_pend_reg)
            begin
                case (wr_addr_reg)
                    {1'b0, `ADDR_ROUTE}:
                        pin_route_select_reg <= hwdata[1:0]; // R01
                    {1'b0, `ADDR_FILTER}:
                        // Out of range values saturate at 20 us R11
                        if (hwdata[31:0] > {27'h0, `FILTER_US_MAX})
                            glitch_filter_time_us_reg <= `FILTER_US_MAX;
                        else
                            glitch_filter_time_us_reg <= hwdata[4:0];
                    {1'b0, `ADDR_POLARITY}:
                        polarity_flip_reg <= hwdata[0]; // R13
                    default:
                        ;
                endcase
            end
            if (take & ~hwrite)
            begin
                case (a)
                    {1'b0, `ADDR_ROUTE}:
                        rdata_reg <= {30'h0, pin_route_select_reg};
                    {1'b0, `ADDR_FILTER}:
                        rdata_reg <= {27'h0, glitch_filter_time_us_reg};
                    {1'b0, `ADDR_POLARITY}:
                        rdata_reg <= {31'h0, polarity_flip_reg};
                    {1'b0, `ADDR_STATUS}:
                        rdata_reg <= {30'h0, filtered, pin_s};
                    `ADDR_FRAME_CNT:
                        rdata_reg <= frame_cnt_reg;
                    `ADDR_TRIG_CNT:
                        rdata_reg <= trig_cnt_reg;
                    default:
                        rdata_reg <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // trigger_input_conditioner

// File: verif/trig_cond_props.sv
// Concurrent checks on the conditioner's event and counter ports
`timescale 1ns/1ps
module trig_cond_props
(
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Events and counters
    input wire frame_done,
    input wire acq_start_trig,
    input wire frame_start_trig,
    input wire frame_cnt_clear,
    input wire trig_cnt_clear,
    input wire [31:0] frame_count,
    input wire [31:0] trig_count
);
    wire ev;
    wire fc;
    assign ev = acq_start_trig | frame_start_trig | frame_cnt_clear
        | trig_cnt_clear;
    assign fc = frame_done & ~frame_cnt_clear;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_one_route: assert property (
        $onehot0({acq_start_trig, frame_start_trig, frame_cnt_clear,
        trig_cnt_clear})) else $error("two events at once");
    a_event_pulse: assert property (ev |=> !ev)
        else $error("event longer than one cycle");
    a_trig_inc: assert property (
        ev && !trig_cnt_clear |=> trig_count == $past(trig_count) + 1)
        else $error("trigger count missed an event");
    a_trig_clear: assert property (
        trig_cnt_clear |=> trig_count == 0)
        else $error("trigger count not cleared");
    a_frame_clear: assert property (
        frame_cnt_clear |=> frame_count == 0)
        else $error("frame count not cleared");
    a_frame_inc: assert property (
        fc |=> frame_count == $past(frame_count) + 1)
        else $error("frame count missed a frame");
    a_trig_hold: assert property (!ev |=> $stable(trig_count))
        else $error("trigger count moved without an event");
    a_frame_hold: assert property (
        !fc && !frame_cnt_clear |=> $stable(frame_count))
        else $error("frame count moved on its own");
endmodule // trig_cond_props

// File: verif/trig_source.sv
// External trigger source driving the opto input pin
`timescale 1ns/1ps
module trig_source
(
    // Clock and pin
    input wire hclk,
    output logic pin
);
    initial pin = 1'b0;
    // Level held whole cycles, then returned to the other level
    task automatic pulse(input logic lvl, input int len);
        @(posedge hclk);
        pin <= lvl;
        repeat (len) @(posedge hclk);
        pin <= ~lvl;
    endtask
endmodule // trig_source

// File: verif/tb_top.sv
// Self-checking bench for the trigger input conditioner
`timescale 1ns/1ps
`include "trig_cond_map.vh"
module tb_top;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic frame_done = 1'b0;
    wire [31:0] hrdata, frame_count, trig_count;
    wire hreadyout, hresp, pin;
    wire [3:0] ev;
    logic [31:0] q, s [4], cnt [4] = '{default: 32'h0};
    int n_errors = 0;
    int n_checks = 0;
    // Route code beside expected events; frame start last for later tests
    logic [5:0] rows [4] = '{6'h24, 6'h38, 6'h01, 6'h12};
    trig_source i_src (.hclk(hclk), .pin(pin));
    trigger_input_conditioner i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .opto_input_pin(pin), .acq_start_trig(ev[0]),
        .frame_start_trig(ev[1]), .frame_cnt_clear(ev[2]),
        .trig_cnt_clear(ev[3]), .frame_done(frame_done),
        .frame_count(frame_count), .trig_count(trig_count));
    initial forever #2.5 hclk = ~hclk;
    always @(posedge hclk)
        for (int i = 0; i < 4; i++)
            if (ev[i] === 1'b1)
                cnt[i] <= cnt[i] + 32'h1;
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 99);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1 && ++k < 99);
        q = hrdata;
        chk("resp", 32'h0, {31'h0, hresp});
        if (k >= 99)
        begin
            n_errors++;
            summarize();
        end
    endtask
    task automatic evchk(input logic [3:0] e);
        for (int j = 0; j < 4; j++)
            chk("events", s[j] + 32'(e[j]), cnt[j]);
        s = cnt;
    endtask
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'(`ADDR_ROUTE), 32'h0);
        chk("route", 32'h1, q);
        ahb(1'b0, 32'h18, 32'h0);
        chk("unmapped", 32'h0, q);
        frame_done <= 1'b1;
        repeat (3) @(posedge hclk);
        frame_done <= 1'b0;
        ahb(1'b0, 32'(`ADDR_FRAME_CNT), 32'h0);
        chk("frames", 32'h3, q);
        s = cnt;
        $display("reset test done");
        foreach (rows[i])
        begin
            ahb(1'b1, 32'(`ADDR_ROUTE), 32'(rows[i][5:4]));
            i_src.pulse(1'b1, 20);
            repeat (20) @(posedge hclk);
            evchk(rows[i][3:0]);
        end
        chk("frames", 32'h0, frame_count);
        chk("triggers", 32'h2, trig_count);
        $display("route table done");
        ahb(1'b1, 32'(`ADDR_FILTER), 32'h1f);
        ahb(1'b0, 32'(`ADDR_FILTER), 32'h0);
        chk("filter", 32'h14, q);
        // Only one line exists, so it always stands selected
        ahb(1'b1, 32'(`ADDR_FILTER), 32'h1);
        // One-cycle gap must restart the 200-cycle stable count
        i_src.pulse(1'b1, 150);
        i_src.pulse(1'b1, 150);
        repeat (250) @(posedge hclk);
        evchk(4'h0);
        fork
            i_src.pulse(1'b1, 260);
            repeat (190) @(posedge hclk);
        join_any
        evchk(4'h0);
        repeat (90) @(posedge hclk);
        evchk(4'h2);
        repeat (250) @(posedge hclk);
        ahb(1'b1, 32'(`ADDR_FILTER), 32'h0);
        ahb(1'b1, 32'(`ADDR_POLARITY), 32'h1);
        repeat (10) @(posedge hclk);
        evchk(4'h2);
        ahb(1'b0, 32'(`ADDR_STATUS), 32'h0);
        chk("status", 32'h2, q);
        i_src.pulse(1'b1, 20);
        repeat (10) @(posedge hclk);
        evchk(4'h2);
        $display("filter and polarity done");
        // Reset in mid-run must clear counters and restore defaults
        hresetn <= 1'b0;
        @(posedge hclk);
        chk("triggers", 32'h0, trig_count);
        chk("frames", 32'h0, frame_count);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'(`ADDR_ROUTE), 32'h0);
        chk("route", 32'h1, q);
        ahb(1'b0, 32'(`ADDR_FILTER), 32'h0);
        chk("filter", 32'h0, q);
        ahb(1'b0, 32'(`ADDR_POLARITY), 32'h0);
        chk("polarity", 32'h0, q);
        repeat (10) @(posedge hclk);
        evchk(4'h0);
        $display("second reset done");
        summarize();
    end
endmodule // tb_top
bind trigger_input_conditioner trig_cond_props i_props (.hclk, .hresetn,
    .frame_done, .acq_start_trig, .frame_start_trig, .frame_cnt_clear,
    .trig_cnt_clear, .frame_count, .trig_count);
